// ===== common/sst_pkg.sv
/*
 * Constants of the scan self-test controller: register map, field
 * positions, reset values and cycle counts.
 * Assumes a 25 MHz system clock and a 32-bit AXI4-Lite register bus.
 */
package sst_pkg;
  localparam int unsigned CLOCK_MHZ = 25;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W = 16;
  localparam int NUM_CPU = 2;
  localparam int CHAIN_LEN = 32;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CYC95 = 8'h04;
  localparam logic [7:0] OFS_CYC99 = 8'h08;
  localparam logic [7:0] OFS_RETADDR = 8'h0C;
  localparam logic [7:0] OFS_COVERAGE = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_MASK = 8'h18;
  localparam logic [7:0] OFS_PROGRESS = 8'h1C;
  localparam logic [7:0] OFS_NMIFLAG = 8'h20;

  // control fields
  localparam int CTRL_START = 0;
  localparam int CTRL_INIT = 1;
  localparam int CTRL_STAGE99 = 2;
  localparam int CTRL_BUSY = 3;

  // status fields
  localparam int ST_W = 5;
  localparam int ST_MICRO_DONE = 0;
  localparam int ST_COMPLETE = 1;
  localparam int ST_LOGIC_FAIL = 2;
  localparam int ST_TIMEOUT_FAIL = 3;
  localparam int ST_NMI_ABORT = 4;

  // reset values
  localparam logic [CNT_W-1:0] RST_CYC95 = 16'h0100;
  localparam logic [CNT_W-1:0] RST_CYC99 = 16'h0100;
  localparam logic [31:0] RST_RETADDR = 32'h0000_0000;
  localparam logic [CNT_W-1:0] RST_COVERAGE = 16'h0400;
  localparam logic [ST_W-1:0] RST_MASK = 5'h00;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // longest wait for the signature result, rounded down
  localparam int unsigned COMPARE_TIMEOUT_NS = 2000;
  localparam int unsigned COMPARE_TIMEOUT_CYC =
    (COMPARE_TIMEOUT_NS * CLOCK_MHZ) / 1000;
  // least length of the core reset pulse, rounded up
  localparam int unsigned CPU_RESET_NS = 200;
  localparam int unsigned CPU_RESET_CYC =
    (CPU_RESET_NS * CLOCK_MHZ + 999) / 1000;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RUN,
    ST_COMPARE,
    ST_RESET_CPU
  } sst_state_type;
endpackage : sst_pkg

// ===== hw/sst_ctrl.sv
/*
 * Scan self-test controller: AXI4-Lite register file, micro-run
 * sequencing, failure detection, nmi flags and interrupt.
 * Assumes the core honours halt, reset and the interrupt hold, and the
 * signature checker answers misr_valid after a run.
 */
// Contract
// - a started run halts the core and hands its logic to scan.
// - a failure sets its status bit and ends the run.
// - failure causes: signature mismatch, or no result before timeout.
// - failures record status, raise nmi and set nmi flag bits.
// - the failure nmi goes to every processor.
// - separate cycles-per-run counts for 95% and 99% stages.
// - programmable return address, reset to 0x0000.
// - programmable coverage target decides when test is complete.
// - progress persists across micro-runs until target is met.
// - run end captures results then resets the core.
// - interrupts to the core are held until it is released.
// - a system nmi aborts the run via a core reset.
// - scan shift and capture are clocked by the system clock.
`timescale 1ns/10ps
module sst_ctrl #(
  parameter int NUM_CPU = sst_pkg::NUM_CPU,
  parameter int CHAIN_LEN = sst_pkg::CHAIN_LEN
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [sst_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [sst_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [sst_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [sst_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic misr_valid,
  input wire logic misr_fail,
  input wire logic sys_nmi,
  output logic cpu_halt,
  output logic cpu_reset,
  output logic intr_hold,
  output logic [31:0] return_addr,
  output logic scan_shift,
  output logic scan_capture,
  output logic [NUM_CPU-1:0] nmi_out,
  output logic irq
);
  import sst_pkg::*;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] val,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = val[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  sst_state_type state_q, state_d;
  logic aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [ADDR_W-1:0] aw_addr_q, aw_addr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic stage99_q, stage99_d;
  logic [CNT_W-1:0] cyc95_q, cyc95_d, cyc99_q, cyc99_d;
  logic [31:0] retaddr_q, retaddr_d;
  logic [CNT_W-1:0] coverage_q, coverage_d;
  logic [CNT_W-1:0] progress_q, progress_d;
  logic [ST_W-1:0] status_q, status_d, mask_q, mask_d;
  logic [NUM_CPU-1:0] nmiflag_q, nmiflag_d;
  logic failed_q, failed_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [ST_W-1:0] ev;
  logic [NUM_CPU-1:0] nmi_clr;
  logic start_req, init_req, rd_clr, do_write, pattern_tick;
  logic [31:0] w;

  sst_scan_seq #(
    .CHAIN_LEN(CHAIN_LEN)
  ) u_seq (
    .clock(clock),
    .reset(reset),
    .run(state_q == ST_RUN),
    .shift_en(scan_shift),
    .capture_en(scan_capture),
    .pattern_tick(pattern_tick)
  );

  always_comb begin
    state_d = state_q;
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    aw_addr_d = aw_addr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    stage99_d = stage99_q;
    cyc95_d = cyc95_q;
    cyc99_d = cyc99_q;
    retaddr_d = retaddr_q;
    coverage_d = coverage_q;
    progress_d = progress_q;
    mask_d = mask_q;
    failed_d = failed_q;
    cnt_d = cnt_q;
    ev = '0;
    nmi_clr = '0;
    start_req = 1'b0;
    init_req = 1'b0;
    rd_clr = 1'b0;
    w = 32'h0000_0000;
    // write channel: address and data taken in either order
    if (!aw_have_q && s_axi_awvalid) begin
      aw_have_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (!w_have_q && s_axi_wvalid) begin
      w_have_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    do_write = aw_have_q && w_have_q && !bvalid_q;
    if (do_write) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = RESP_OKAY;
      case (aw_addr_q)
        OFS_CTRL: begin
          w = merge(32'h0000_0000, wdata_q, wstrb_q);
          start_req = w[CTRL_START];
          init_req = w[CTRL_INIT];
          if (wstrb_q[0]) begin
            stage99_d = w[CTRL_STAGE99];
          end
        end
        OFS_CYC95: begin
          w = merge({16'h0000, cyc95_q}, wdata_q, wstrb_q);
          cyc95_d = w[CNT_W-1:0];
        end
        OFS_CYC99: begin
          w = merge({16'h0000, cyc99_q}, wdata_q, wstrb_q);
          cyc99_d = w[CNT_W-1:0];
        end
        OFS_RETADDR: begin
          retaddr_d = merge(retaddr_q, wdata_q, wstrb_q);
        end
        OFS_COVERAGE: begin
          w = merge({16'h0000, coverage_q}, wdata_q, wstrb_q);
          coverage_d = w[CNT_W-1:0];
        end
        OFS_MASK: begin
          w = merge({27'h0000000, mask_q}, wdata_q, wstrb_q);
          mask_d = w[ST_W-1:0];
        end
        OFS_NMIFLAG: begin
          w = merge(32'h0000_0000, wdata_q, wstrb_q);
          nmi_clr = w[NUM_CPU-1:0];
        end
        OFS_STATUS, OFS_PROGRESS: begin
        end
        default: begin
          bresp_d = RESP_SLVERR;
        end
      endcase
    end
    // read channel
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid && !rvalid_q) begin
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      rdata_d = 32'h0000_0000;
      case (s_axi_araddr)
        OFS_CTRL: begin
          rdata_d[CTRL_STAGE99] = stage99_q;
          rdata_d[CTRL_BUSY] = (state_q != ST_IDLE);
        end
        OFS_CYC95: rdata_d[CNT_W-1:0] = cyc95_q;
        OFS_CYC99: rdata_d[CNT_W-1:0] = cyc99_q;
        OFS_RETADDR: rdata_d = retaddr_q;
        OFS_COVERAGE: rdata_d[CNT_W-1:0] = coverage_q;
        OFS_STATUS: begin
          rdata_d[ST_W-1:0] = status_q;
          rd_clr = 1'b1;
        end
        OFS_MASK: rdata_d[ST_W-1:0] = mask_q;
        OFS_PROGRESS: rdata_d[CNT_W-1:0] = progress_q;
        OFS_NMIFLAG: rdata_d[NUM_CPU-1:0] = nmiflag_q;
        default: rresp_d = RESP_SLVERR;
      endcase
    end
    // initialisation restarts the coverage walk
    if (init_req && state_q == ST_IDLE) begin
      progress_d = '0;
      failed_d = 1'b0;
    end
    // micro-run sequencing
    case (state_q)
      ST_IDLE: begin
        if (start_req && !init_req && !failed_q &&
            progress_q < coverage_q) begin
          state_d = ST_RUN;
          cnt_d = stage99_q ? cyc99_q : cyc95_q;
        end
      end
      ST_RUN: begin
        if (pattern_tick && progress_q != {CNT_W{1'b1}}) begin
          progress_d = progress_q + 16'h0001;
        end
        if (sys_nmi) begin
          ev[ST_NMI_ABORT] = 1'b1;
          cnt_d = 16'(CPU_RESET_CYC);
          state_d = ST_RESET_CPU;
        end else if (cnt_q <= 16'h0001) begin
          cnt_d = 16'(COMPARE_TIMEOUT_CYC);
          state_d = ST_COMPARE;
        end else begin
          cnt_d = cnt_q - 16'h0001;
        end
      end
      ST_COMPARE: begin
        if (sys_nmi) begin
          ev[ST_NMI_ABORT] = 1'b1;
          cnt_d = 16'(CPU_RESET_CYC);
          state_d = ST_RESET_CPU;
        end else if (misr_valid) begin
          ev[ST_MICRO_DONE] = 1'b1;
          if (misr_fail) begin
            ev[ST_LOGIC_FAIL] = 1'b1;
            failed_d = 1'b1;
          end else if (progress_q >= coverage_q) begin
            ev[ST_COMPLETE] = 1'b1;
          end
          cnt_d = 16'(CPU_RESET_CYC);
          state_d = ST_RESET_CPU;
        end else if (cnt_q <= 16'h0001) begin
          ev[ST_TIMEOUT_FAIL] = 1'b1;
          failed_d = 1'b1;
          cnt_d = 16'(CPU_RESET_CYC);
          state_d = ST_RESET_CPU;
        end else begin
          cnt_d = cnt_q - 16'h0001;
        end
      end
      ST_RESET_CPU: begin
        if (cnt_q <= 16'h0001) begin
          state_d = ST_IDLE;
        end else begin
          cnt_d = cnt_q - 16'h0001;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    // sticky status: a new event wins over the read clear
    status_d = (rd_clr ? '0 : status_q) | ev;
    // failure raises the nmi flag of every cpu, set wins over clear
    nmiflag_d = nmiflag_q & ~nmi_clr;
    if (ev[ST_LOGIC_FAIL] || ev[ST_TIMEOUT_FAIL]) begin
      nmiflag_d = {NUM_CPU{1'b1}};
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_q <= ST_IDLE;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= '0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0000_0000;
      stage99_q <= 1'b0;
      cyc95_q <= RST_CYC95;
      cyc99_q <= RST_CYC99;
      retaddr_q <= RST_RETADDR;
      coverage_q <= RST_COVERAGE;
      progress_q <= '0;
      status_q <= '0;
      mask_q <= RST_MASK;
      nmiflag_q <= '0;
      failed_q <= 1'b0;
      cnt_q <= '0;
    end else begin
      state_q <= state_d;
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      aw_addr_q <= aw_addr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      stage99_q <= stage99_d;
      cyc95_q <= cyc95_d;
      cyc99_q <= cyc99_d;
      retaddr_q <= retaddr_d;
      coverage_q <= coverage_d;
      progress_q <= progress_d;
      status_q <= status_d;
      mask_q <= mask_d;
      nmiflag_q <= nmiflag_d;
      failed_q <= failed_d;
      cnt_q <= cnt_d;
    end
  end

  assign s_axi_awready = !aw_have_q;
  assign s_axi_wready = !w_have_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign cpu_halt = (state_q != ST_IDLE);
  assign intr_hold = (state_q != ST_IDLE);
  assign cpu_reset = (state_q == ST_RESET_CPU);
  assign return_addr = retaddr_q;
  assign nmi_out = nmiflag_q;
  assign irq = |(status_q & mask_q);
endmodule : sst_ctrl

// ===== hw/sst_scan_seq.sv
/*
 * Scan sequencer: while run is high, shifts the chains for chain_len
 * cycles then gives one capture cycle, and flags each finished pattern.
 * Assumes the caller holds run for the whole micro-run.
 */
`timescale 1ns/10ps
module sst_scan_seq #(
  parameter int CHAIN_LEN = sst_pkg::CHAIN_LEN
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic run,
  output logic shift_en,
  output logic capture_en,
  output logic pattern_tick
);
  import sst_pkg::*;

  logic [15:0] bit_q;
  logic [15:0] bit_d;
  logic shift_q;
  logic shift_d;
  logic cap_q;
  logic cap_d;

  always_comb begin
    bit_d = bit_q;
    shift_d = 1'b0;
    cap_d = 1'b0;
    if (!run) begin
      bit_d = 16'h0000;
    end else if (bit_q == 16'(CHAIN_LEN)) begin
      bit_d = 16'h0000;
      cap_d = 1'b1;
    end else begin
      bit_d = bit_q + 16'h0001;
      shift_d = 1'b1;
    end
  end

  // shift and capture both run on the system clock
  always_ff @(posedge clock) begin
    if (reset) begin
      bit_q <= 16'h0000;
      shift_q <= 1'b0;
      cap_q <= 1'b0;
    end else begin
      bit_q <= bit_d;
      shift_q <= shift_d;
      cap_q <= cap_d;
    end
  end

  assign shift_en = shift_q;
  assign capture_en = cap_q;
  assign pattern_tick = cap_q;
endmodule : sst_scan_seq

// ===== test/sst_core_model.sv
/* model of the core side: answers the signature check of a run
   assumes halt and reset from sst_ctrl; delay counts from halt */
`timescale 1ns/10ps
module sst_core_model (
  input wire logic clock,
  input wire logic reset,
  input wire logic cpu_halt,
  input wire logic cpu_reset,
  input wire logic [7:0] delay,
  input wire logic fail,
  input wire logic mute,
  output logic misr_valid,
  output logic misr_fail
);
  int n = 0;
  logic tog = 1'h0;
  always @(posedge clock) begin
    tog <= ~tog;
    if (reset || !cpu_halt || cpu_reset) begin
      n <= 0;
    end else begin
      n <= n + 1;
    end
  end
  // result held until the core reset; idle line keeps changing
  assign misr_valid = cpu_halt && !cpu_reset && !mute && n >= delay;
  assign misr_fail = misr_valid ? fail : tog;
endmodule : sst_core_model

// ===== test/sst_ctrl_properties.sv
/* timing checks on the ports of sst_ctrl
   assumes the bind below and one clock domain */
`timescale 1ns/10ps
module sst_ctrl_properties #(
  parameter int NUM_CPU = 2
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic cpu_halt,
  input wire logic cpu_reset,
  input wire logic intr_hold,
  input wire logic scan_shift,
  input wire logic scan_capture,
  input wire logic [NUM_CPU-1:0] nmi_out,
  input wire logic irq
);
  logic [7:0] idle_q, idle_d;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  // halted cycles with no scan activity: the wait for the result
  always_comb begin
    idle_d = 8'h00;
    if (cpu_halt && !cpu_reset && !scan_shift && !scan_capture) begin
      idle_d = idle_q + 8'h01;
    end
  end
  always_ff @(posedge clock) begin
    if (reset) begin
      idle_q <= 8'h00;
    end else begin
      idle_q <= idle_d;
    end
  end

  a_hold_follows_halt: assert property (intr_hold == cpu_halt)
    else $error("interrupt hold differs from halt");
  a_reset_in_run: assert property (cpu_reset |-> cpu_halt)
    else $error("core reset outside a run");
  a_reset_five: assert property (
    $rose(cpu_reset) |-> cpu_reset [*5] ##1 !cpu_reset)
    else $error("core reset length wrong");
  a_scan_halted: assert property (
    scan_shift || scan_capture |-> cpu_halt)
    else $error("scan activity while core runs");
  a_end_via_reset: assert property (
    $fell(cpu_halt) |-> $past(cpu_reset))
    else $error("run ended without core reset");
  a_nmi_every_cpu: assert property (
    $rose(|nmi_out) |-> &nmi_out && cpu_halt)
    else $error("nmi not raised to all cores at run end");
  a_compare_bounded: assert property (idle_q <= 8'h37)
    else $error("result wait not cut short");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");

  c_reset: cover property ($rose(cpu_reset));
  c_nmi: cover property ($rose(|nmi_out));
  c_irq: cover property ($rose(irq));
endmodule : sst_ctrl_properties

bind sst_ctrl sst_ctrl_properties #(.NUM_CPU(NUM_CPU)) props (
  .clock, .reset, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .cpu_halt, .cpu_reset, .intr_hold, .scan_shift,
  .scan_capture, .nmi_out, .irq
);

// ===== test/test_sst_ctrl.sv
/* bench for sst_ctrl: bus master, core model, run scenarios
   assumes sst_core_model and the bound checker */
`timescale 1ns/10ps
module test_sst_ctrl;
  import sst_pkg::*;
  logic clock = 1'h0, reset = 1'h1, sys_nmi = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, delay = 8'h01;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, return_addr, rnd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, fail = 1'h0;
  logic mute = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, misr_valid, misr_fail, cpu_halt;
  logic cpu_reset, intr_hold, scan_shift, scan_capture, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, nmi_out;
  logic [4:0] msk = 5'h1F;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int errors = 0, compares = 0, seed = 32'hC8D0, i, runs = 0;
  localparam int RUN_LIMIT = 750;
  logic [7:0] ra [10] = '{OFS_CTRL, OFS_CYC95, OFS_CYC99, OFS_RETADDR,
    OFS_COVERAGE, OFS_STATUS, OFS_MASK, OFS_PROGRESS, OFS_NMIFLAG, 8'h24};
  logic [31:0] rv [10] = '{32'h0, {16'h0000, RST_CYC95},
    {16'h0000, RST_CYC99}, RST_RETADDR, {16'h0000, RST_COVERAGE}, 32'h0,
    {27'h0000000, RST_MASK}, 32'h0, 32'h0, 32'h0};

  always #20 clock = ~clock;

  sst_ctrl dut (.clock, .reset, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .misr_valid, .misr_fail,
    .sys_nmi, .cpu_halt, .cpu_reset, .intr_hold, .return_addr,
    .scan_shift, .scan_capture, .nmi_out, .irq);
  sst_core_model core (.clock, .reset, .cpu_halt, .cpu_reset, .delay,
    .fail, .mute, .misr_valid, .misr_fail);

  task automatic finish_test();
    if (errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [33:0] s, input logic [33:0] e);
    compares++;
    if (s !== e) begin
      errors++;
      $display("unexpected at %0t: saw %h wanted %h", $time, s, e);
    end
  endtask : chk

  task automatic wt(ref logic s, input logic v);
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
      if (n > 3000) begin
        errors++;
        finish_test();
      end
    end while (s !== v);
  endtask : wt

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] e = RESP_OKAY);
    bq.push_back(e);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    fork
      begin
        wt(s_axi_awready, 1'h1);
        s_axi_awvalid <= 1'h0;
      end
      begin
        wt(s_axi_wready, 1'h1);
        s_axi_wvalid <= 1'h0;
      end
    join
    wt(s_axi_bvalid, 1'h1);
    s_axi_bready <= 1'h0;
    @(posedge clock);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    rq.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    wt(s_axi_arready, 1'h1);
    s_axi_arvalid <= 1'h0;
    wt(s_axi_rvalid, 1'h1);
    s_axi_rready <= 1'h0;
    @(posedge clock);
  endtask : rd

  // one micro-run: start, follow halt and reset, then check status
  task automatic run(input logic [31:0] c, input logic [4:0] st);
    runs++;
    wr(OFS_CTRL, c);
    wt(cpu_halt, 1'h1);
    chk(intr_hold, 1'h1);
    rd(OFS_CTRL, {RESP_OKAY, 28'h0000000, 1'h1, c[2], 2'h0});
    wt(cpu_reset, 1'h1);
    wt(cpu_halt, 1'h0);
    chk(irq, |(st & msk));
    chk(nmi_out, {2{|st[3:2]}});
    rd(OFS_STATUS, {RESP_OKAY, 27'h0, st});
    @(posedge clock);
    chk(irq, 1'h0);
  endtask : run

  always @(posedge clock) begin
    if (s_axi_rvalid === 1'h1 && s_axi_rready === 1'h1 && rq.size() > 0)
      chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
    if (s_axi_bvalid === 1'h1 && s_axi_bready === 1'h1 && bq.size() > 0)
      chk(s_axi_bresp, bq.pop_front());
  end

  initial begin
    repeat (12) @(posedge clock);
    reset <= 1'h0;
    chk({cpu_halt, nmi_out, irq}, 4'h0);
    for (i = 0; i < 10; i++) begin
      rd(ra[i], {i == 9 ? RESP_SLVERR : RESP_OKAY, rv[i]});
    end
    wr(8'h24, 32'h0, RESP_SLVERR);
    rnd = $random(seed);
    wr(OFS_RETADDR, rnd);
    @(posedge clock);
    chk(return_addr, rnd);
    rd(OFS_RETADDR, {RESP_OKAY, rnd});
    wr(OFS_CYC95, 32'h43);
    wr(OFS_COVERAGE, 32'h3);
    wr(OFS_MASK, 32'h1F);
    wr(OFS_CTRL, 32'h2);
    run(32'h1, 5'h01);
    rd(OFS_PROGRESS, {RESP_OKAY, 32'h2});
    run(32'h1, 5'h03);
    chk(runs <= RUN_LIMIT, 1'h1);
    wr(OFS_COVERAGE, 32'h2);
    wr(OFS_CYC99, 32'h28);
    wr(OFS_CTRL, 32'h6);
    run(32'h5, 5'h01);
    wr(OFS_CTRL, 32'h2);
    delay <= 8'h6B;
    run(32'h1, 5'h03);
    wr(OFS_CTRL, 32'h2);
    delay <= 8'h01;
    fail <= 1'h1;
    run(32'h1, 5'h05);
    rd(OFS_NMIFLAG, {RESP_OKAY, 32'h3});
    wr(OFS_CTRL, 32'h1);
    repeat (4) @(posedge clock);
    chk(cpu_halt, 1'h0);
    wr(OFS_NMIFLAG, 32'h3);
    @(posedge clock);
    chk(nmi_out, 2'h0);
    wr(OFS_CTRL, 32'h2);
    fail <= 1'h0;
    mute <= 1'h1;
    msk = 5'h01;
    wr(OFS_MASK, 32'h1);
    run(32'h1, 5'h08);
    wr(OFS_NMIFLAG, 32'h3);
    wr(OFS_CTRL, 32'h2);
    mute <= 1'h0;
    fork
      run(32'h1, 5'h10);
      begin
        wt(scan_shift, 1'h1);
        sys_nmi <= 1'h1;
        wt(cpu_reset, 1'h1);
        sys_nmi <= 1'h0;
      end
    join
    finish_test();
  end
endmodule : test_sst_ctrl
